// file: core/cpwm_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpwm_cfg.svh"

// Function
// - compare value counts timebase clocks of the low part of each period.
// - output goes high on counter match, low on counter overflow.
// - wide pwm runs only with compare, pwm and wide select bits all set.
// - writing the low compare byte clears the compare enable bit.
// - writing the high compare byte sets the compare enable bit.
// - high fraction of the period is 65536 minus compare, over 65536.
// - overflow flag is set by hardware and only cleared by software.
// - a match sets the module flag and requests an interrupt if enabled.
// - module flag is not cleared on interrupt entry; software clears it.
module cpwm_channel (
    input  wire logic        pclk,              // system clock, 50 MHz
    input  wire logic        presetn,           // async reset, active low
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb access phase
    input  wire logic        pwrite,            // apb write
    input  wire logic [7:0]  paddr,             // apb byte address
    input  wire logic [31:0] pwdata,            // apb write data
    output logic      [31:0] prdata,            // apb read data
    output logic             pready,            // apb ready
    output logic             pslverr,           // apb error, unmapped
    output logic             module_output_pin, // pwm output
    output logic             irq                // level interrupt
);
    import cpwm_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cpwm_apb_req_type req;
    cpwm_mode_type    mode_q;
    logic [7:0]       ctrl_q;
    logic [15:0]      cmp_q;
    logic [15:0]      cnt_q;
    logic [15:0]      cnt_d;
    logic [1:0]       irq_st_q;
    logic [1:0]       irq_en_q;
    logic [1:0]       irq_set;
    logic             pin_q;
    logic             irq_q;
    logic [31:0]      prdata_q;
    logic             pready_q;
    logic             pslverr_q;
    logic             run;
    logic             active;
    logic             tick;
    logic             ovf_evt;
    logic             match_evt;
    logic             wr;
    logic             setup;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `CPWM_OFS_CTRL) || (a == `CPWM_OFS_MODE) ||
                    (a == `CPWM_OFS_CMP_LO) || (a == `CPWM_OFS_CMP_HI) ||
                    (a == `CPWM_OFS_COUNT) || (a == `CPWM_OFS_IRQ_STAT) ||
                    (a == `CPWM_OFS_IRQ_CLR) || (a == `CPWM_OFS_IRQ_EN);
    endfunction : is_mapped

    function automatic logic wr_at(input cpwm_apb_req_type r, input logic [7:0] a);
        wr_at = r.sel && r.enable && r.write && (r.addr == a);
    endfunction : wr_at

    assign req    = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign setup  = psel && !penable;
    assign wr     = psel && penable && pwrite && pready_q;

    // ------------------------------------------------------------
    // apb slave: one access cycle, data registered in setup
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !is_mapped(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (setup && !pwrite) begin
            unique case (paddr)
                `CPWM_OFS_CTRL:     prdata_q <= {24'h000000, ctrl_q};
                `CPWM_OFS_MODE:     prdata_q <= {24'h000000, mode_q};
                `CPWM_OFS_CMP_LO:   prdata_q <= {24'h000000, cmp_q[7:0]};
                `CPWM_OFS_CMP_HI:   prdata_q <= {24'h000000, cmp_q[15:8]};
                `CPWM_OFS_COUNT:    prdata_q <= {16'h0000, cnt_q};
                `CPWM_OFS_IRQ_STAT: prdata_q <= {30'h0, irq_st_q};
                `CPWM_OFS_IRQ_EN:   prdata_q <= {30'h0, irq_en_q};
                default:            prdata_q <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // counter timebase
    // ------------------------------------------------------------
    assign run  = ctrl_q[`CPWM_CTRL_RUN_BIT];
    assign tick = run;
    assign cnt_d = (cnt_q == `CPWM_CNT_MAX) ? `CPWM_CNT_RESET : cnt_q + 16'h0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `CPWM_CNT_RESET;
        end else if (tick) begin
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // mode and compare registers
    // ------------------------------------------------------------
    assign active = mode_q.compare_enable_bit && mode_q.pwm_enable_bit &&
                    mode_q.wide_pwm_select_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `CPWM_MODE_RESET;
        end else if (wr && wr_at(req, `CPWM_OFS_MODE)) begin
            mode_q <= pwdata[7:0];
        end else if (wr && wr_at(req, `CPWM_OFS_CMP_LO)) begin
            mode_q.compare_enable_bit <= 1'b0;
        end else if (wr && wr_at(req, `CPWM_OFS_CMP_HI)) begin
            mode_q.compare_enable_bit <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_q <= `CPWM_CMP_RESET;
        end else if (wr && wr_at(req, `CPWM_OFS_CMP_LO)) begin
            cmp_q[7:0] <= pwdata[7:0];
        end else if (wr && wr_at(req, `CPWM_OFS_CMP_HI)) begin
            cmp_q[15:8] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // match and overflow events, on the count about to be shown
    // ------------------------------------------------------------
    assign ovf_evt   = tick && (cnt_q == `CPWM_CNT_MAX);
    assign match_evt = tick && active && (cnt_d == cmp_q);

    // low while count below compare, high from compare to wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else if (!active) begin
            pin_q <= 1'b0;
        end else if (match_evt) begin
            pin_q <= 1'b1;
        end else if (ovf_evt) begin
            pin_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control/status: software r/w, hardware set wins
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CPWM_CTRL_RESET;
        end else begin
            if (wr && wr_at(req, `CPWM_OFS_CTRL)) begin
                ctrl_q <= pwdata[7:0];
            end
            if (ovf_evt) begin
                ctrl_q[`CPWM_CTRL_OVF_BIT] <= 1'b1;
            end
            if (match_evt) begin
                ctrl_q[`CPWM_CTRL_M0_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, clear and enable
    // ------------------------------------------------------------
    assign irq_set[`CPWM_IRQ_OVF_BIT]   = ovf_evt;
    assign irq_set[`CPWM_IRQ_MATCH_BIT] = match_evt && mode_q.match_irq_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= 2'h0;
        end else if (wr && wr_at(req, `CPWM_OFS_IRQ_CLR)) begin
            irq_st_q <= (irq_st_q & ~pwdata[1:0]) | irq_set;
        end else begin
            irq_st_q <= irq_st_q | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= 2'h0;
        end else if (wr && wr_at(req, `CPWM_OFS_IRQ_EN)) begin
            irq_en_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_st_q & irq_en_q);
        end
    end

    assign prdata            = prdata_q;
    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
    assign module_output_pin = pin_q;
    assign irq               = irq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_match_seen;
        match_evt;
    endsequence

    sequence s_pin_high_after;
        ##1 module_output_pin;
    endsequence

    a_pin_high_match: assert property (@(posedge pclk) disable iff (!presetn)
        s_match_seen |-> s_pin_high_after)
        else $error("pin not high after match");

    a_pin_low_ovf: assert property (@(posedge pclk) disable iff (!presetn)
        (ovf_evt && !match_evt && active) |=> !module_output_pin)
        else $error("pin not low after overflow");

    a_mode_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        !active |=> !module_output_pin)
        else $error("pin driven outside wide pwm mode");

    sequence s_cmp_lo_wr;
        wr && (paddr == `CPWM_OFS_CMP_LO);
    endsequence

    sequence s_cmp_hi_wr;
        wr && (paddr == `CPWM_OFS_CMP_HI);
    endsequence

    a_cmp_en_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmp_lo_wr |=> !mode_q.compare_enable_bit)
        else $error("compare enable not cleared by low write");

    a_cmp_en_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmp_hi_wr |=> mode_q.compare_enable_bit)
        else $error("compare enable not set by high write");

    a_ovf_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_q[`CPWM_CTRL_OVF_BIT] && !(wr && paddr == `CPWM_OFS_CTRL))
        |=> ctrl_q[`CPWM_CTRL_OVF_BIT])
        else $error("overflow flag cleared by hardware");

    a_match_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        match_evt |=> ctrl_q[`CPWM_CTRL_M0_BIT])
        else $error("match flag not set");

    a_match_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (match_evt && mode_q.match_irq_en && irq_en_q[`CPWM_IRQ_MATCH_BIT]
         && !wr) |-> ##2 irq)
        else $error("match interrupt not raised");

    a_counter_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (run && cnt_q == `CPWM_CNT_MAX) |=> (cnt_q == `CPWM_CNT_RESET))
        else $error("counter did not wrap to zero");

    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        (run && cnt_q != `CPWM_CNT_MAX) |=> (cnt_q == $past(cnt_q) + 16'h0001))
        else $error("counter did not step by one");

    a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !run |=> $stable(cnt_q))
        else $error("counter moved while stopped");

    a_ovf_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_evt |=> ctrl_q[`CPWM_CTRL_OVF_BIT])
        else $error("overflow flag not set");

    a_match_status: assert property (@(posedge pclk) disable iff (!presetn)
        (match_evt && mode_q.match_irq_en) |=> irq_st_q[`CPWM_IRQ_MATCH_BIT])
        else $error("match status not set");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        (|(irq_st_q & irq_en_q)) |=> irq)
        else $error("interrupt not raised for enabled status");

    a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(irq_st_q & irq_en_q)) |=> !irq)
        else $error("interrupt raised with no enabled status");

    a_pin_rise_match: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(module_output_pin) |-> $past(match_evt))
        else $error("pin rose without a match");

    a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready)
        else $error("no ready after setup");

endmodule : cpwm_channel
`default_nettype wire

// file: core/cpwm_cfg.svh
`ifndef CPWM_CFG_SVH
`define CPWM_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CPWM_OFS_CTRL      8'h00
`define CPWM_OFS_MODE      8'h04
`define CPWM_OFS_CMP_LO    8'h08
`define CPWM_OFS_CMP_HI    8'h0C
`define CPWM_OFS_COUNT     8'h10
`define CPWM_OFS_IRQ_STAT  8'h14
`define CPWM_OFS_IRQ_CLR   8'h18
`define CPWM_OFS_IRQ_EN    8'h1C

// ----------------------------------------------------------------
// array_control_status fields
// ----------------------------------------------------------------
`define CPWM_CTRL_OVF_BIT  7
`define CPWM_CTRL_RUN_BIT  6
`define CPWM_CTRL_M0_BIT   0
`define CPWM_CTRL_RESET    8'h00

// ----------------------------------------------------------------
// interrupt status fields
// ----------------------------------------------------------------
`define CPWM_IRQ_OVF_BIT   0
`define CPWM_IRQ_MATCH_BIT 1

// ----------------------------------------------------------------
// other constants
// ----------------------------------------------------------------
`define CPWM_MODE_RESET    8'h00
`define CPWM_CNT_MAX       16'hFFFF
`define CPWM_CNT_RESET     16'h0000
`define CPWM_CMP_RESET     16'h0000

`endif

// file: core/cpwm_pkg.sv
`default_nettype none

package cpwm_pkg;

    // module mode register layout, msb first
    typedef struct packed {
        logic wide_pwm_select_bit;
        logic compare_enable_bit;
        logic cap_pos;
        logic cap_neg;
        logic match_en;
        logic toggle_en;
        logic pwm_enable_bit;
        logic match_irq_en;
    } cpwm_mode_type;

    typedef struct packed {
        logic       sel;
        logic       enable;
        logic       write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } cpwm_apb_req_type;

endpackage : cpwm_pkg

`default_nettype wire

// file: testbench/cpwm_load.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// external load: measures the high pulses on the pwm pin
// ----------------------------------------------------------------
module cpwm_load (
    input  wire logic        pclk,     // system clock
    input  wire logic        presetn,  // async reset, active low
    input  wire logic        drive,    // pwm pin from the block
    output logic      [31:0] high_len, // length of last high pulse
    output logic      [31:0] rises     // rising edges seen
);
    logic        drive_q;
    logic [31:0] run_len_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_q   <= 1'b0;
            run_len_q <= 32'h0;
            high_len  <= 32'h0;
            rises     <= 32'h0;
        end else begin
            drive_q   <= drive;
            run_len_q <= drive ? run_len_q + 32'h1 : 32'h0;
            if (drive && !drive_q) rises <= rises + 32'h1;
            if (!drive && drive_q) high_len <= run_len_q;
        end
    end
endmodule : cpwm_load

`default_nettype wire

// file: testbench/counter_array_pwm16_channel_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpwm_cfg.svh"

module counter_array_pwm16_channel_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, high_len, rises;
    logic        slv_err;
    int          mismatches, n_compared, i;

    cpwm_channel uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .module_output_pin(pin), .irq(irq));
    cpwm_load load (.pclk(pclk), .presetn(presetn), .drive(pin), .high_len(high_len),
        .rises(rises));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // this wait ends once pready is seen high
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        slv_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_compare_write;
        apb(1'b1, `CPWM_OFS_MODE, 32'h0000_00C3);
        apb(1'b1, `CPWM_OFS_CMP_LO, 32'h0000_00FE);
        rd_chk(`CPWM_OFS_MODE, 32'h0000_0083);
        apb(1'b1, `CPWM_OFS_CMP_HI, 32'h0000_00FF);
        rd_chk(`CPWM_OFS_MODE, 32'h0000_00C3);
    endtask : t_compare_write

    task automatic t_pwm_cycle;
        apb(1'b1, `CPWM_OFS_IRQ_EN, 32'h0000_0003);
        chk({31'h0, pin}, 32'h0);
        apb(1'b1, `CPWM_OFS_CTRL, 32'h0000_0040);
        for (i = 0; i < 70000 && pin !== 1'b1; i++) @(posedge pclk);
        chk({31'h0, pin}, 32'h1);
        // low for 0xFFFE counts, seen one edge late
        chk(i, 32'h0000_FFFF);
        for (i = 0; i < 10 && pin !== 1'b0; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk(high_len, 32'h2);
        chk(rises, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd_chk(`CPWM_OFS_CTRL, 32'h0000_00C1);
        rd_chk(`CPWM_OFS_IRQ_STAT, 32'h0000_0003);
        rd_chk(`CPWM_OFS_IRQ_EN, 32'h0000_0003);
        chk({31'h0, slv_err}, 32'h0);
    endtask : t_pwm_cycle

    // new compare after the match interrupt, but outside wide pwm mode
    task automatic t_mode_gate;
        apb(1'b1, `CPWM_OFS_CTRL, 32'h0000_0040);
        apb(1'b1, `CPWM_OFS_MODE, 32'h0000_0043);
        apb(1'b1, `CPWM_OFS_CMP_LO, 32'h0000_0040);
        apb(1'b1, `CPWM_OFS_CMP_HI, 32'h0000_0000);
        repeat (100) @(posedge pclk);
        chk({31'h0, pin}, 32'h0);
        chk(rises, 32'h1);
        rd_chk(`CPWM_OFS_CTRL, 32'h0000_0040);
        rd_chk(`CPWM_OFS_MODE, 32'h0000_0043);
        rd_chk(`CPWM_OFS_CMP_LO, 32'h0000_0040);
        rd_chk(`CPWM_OFS_CMP_HI, 32'h0000_0000);
    endtask : t_mode_gate

    task automatic t_clear_flags;
        logic [31:0] held;
        apb(1'b1, `CPWM_OFS_CTRL, 32'h0000_0000);
        rd_chk(`CPWM_OFS_CTRL, 32'h0000_0000);
        apb(1'b0, `CPWM_OFS_COUNT, 32'h0);
        held = rd;
        repeat (10) @(posedge pclk);
        rd_chk(`CPWM_OFS_COUNT, held);
        apb(1'b1, `CPWM_OFS_IRQ_CLR, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(`CPWM_OFS_IRQ_STAT, 32'h0000_0000);
        rd_chk(8'h20, 32'h0000_0000);
        chk({31'h0, slv_err}, 32'h1);
    endtask : t_clear_flags

    // ----------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        mismatches = 0;
        n_compared = 0;
        presetn    <= 1'b0;
        psel       <= 1'b0;
        penable    <= 1'b0;
        pwrite     <= 1'b0;
        paddr      <= 8'h00;
        pwdata     <= 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`CPWM_OFS_CTRL, 32'h0000_0000);
        rd_chk(`CPWM_OFS_MODE, 32'h0000_0000);
        rd_chk(`CPWM_OFS_COUNT, 32'h0000_0000);
        t_compare_write();
        t_pwm_cycle();
        t_mode_gate();
        t_clear_flags();
        print_verdict();
    end

    initial begin
        repeat (90000) @(posedge pclk);
        mismatches++;
        $display("ERROR %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : counter_array_pwm16_channel_tb

`default_nettype wire
